/* rtl/mcas_map.vh */
// Register map, field positions and reset values of the monitor configuration and alarm block
// What this block does
// - Run bit high uses programmed limits; low selects defaults, programmed limits kept.
// - After lock is written the run bit is read-only.
// - Lock sets once; lockable fields frozen until power cycle.
// - Read-only ready flag goes high once the device is ready to monitor.
// - Full-speed bit drives all fans full; resets zero; never locked.
// - Lockable power-reporting bit, informational for software only.
// - Spin-up-disable bit holds pulse outputs high for whole spin-up timeout.
// - Timeout-disable bit turns off the serial-bus timeout; lockable.
// - Supply-scale bit selects 5 V (one) or 3.3 V (zero) supply measurement.
// - Configuration register at 0x40, resets to 0x00.
// - Status bits 0..3 latch 2.5 V, core, supply and 5 V rail alarms.
// - Status bits 4..6 latch remote one, local and remote two temperature alarms.
// - Reading status clears a latched bit only if its condition has gone.
// - Status bit 7 is the OR of the secondary status register.
// - Status register at 0x41, read-only, resets to 0x00.
// - Writes to lockable fields after lock leave them unchanged.
`ifndef MCAS_MAP_VH
`define MCAS_MAP_VH
`define MCAS_ADDR_W          8
`define MCAS_CFG_IDX         8'h40
`define MCAS_STAT_IDX        8'h41
`define MCAS_IRQ_EN_IDX      8'h50
`define MCAS_IRQ_STAT_IDX    8'h51
`define MCAS_IRQ_CLR_IDX     8'h52
`define MCAS_CFG_RESET       8'h00
`define MCAS_STAT_RESET      8'h00
`define MCAS_CFG_RUN         0
`define MCAS_CFG_LOCK        1
`define MCAS_CFG_READY       2
`define MCAS_CFG_FULL        3
`define MCAS_CFG_POWER       4
`define MCAS_CFG_SPIN        5
`define MCAS_CFG_BUS_TIMEOUT_DISABLE       6
`define MCAS_CFG_SCALE       7
`define MCAS_CFG_LOCKABLE    8'hD3
`define MCAS_STAT_SUMMARY    7
`define MCAS_READY_NS        1000
`define MCAS_CLK_MHZ         250
`define MCAS_READY_CYC       ((`MCAS_READY_NS * `MCAS_CLK_MHZ + 999) / 1000)
`define MCAS_RESP_OKAY       2'b00
`define MCAS_RESP_SLVERR     2'b10
`endif

/* rtl/mcas_regs.v */
// Configuration and first alarm status registers behind an AXI4-Lite slave
`timescale 1ns/10ps
`include "mcas_map.vh"
module mcas_regs #(
  parameter READY_CYCLES = `MCAS_READY_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [6:0]  limit_violation,
  input  wire [7:0]  secondary_status,
  output reg         monitor_run,
  output reg         config_locked,
  output reg         fans_full_speed,
  output reg         power_report,
  output reg         spinup_pulse_disable,
  output reg         bus_timeout_disable,
  output reg         supply_scale_select,
  output reg         irq
);

  reg  [6:0]  viol_s1;
  reg  [6:0]  viol;
  reg  [7:0]  sec_s1;
  reg  [7:0]  sec;
  reg  [7:0]  cfg;
  reg  [6:0]  alarm;
  reg  [7:0]  irq_stat;
  reg  [7:0]  irq_en;
  reg         ready;
  reg  [15:0] ready_cnt;
  reg         aw_held;
  reg         w_held;
  reg  [7:0]  aw_idx;
  reg  [7:0]  w_byte;
  reg         w_lane0;
  reg  [7:0]  next_cfg;
  reg  [7:0]  rd_val;
  reg         rd_ok;
  reg         wr_ok;
  reg         next_irq;

  wire        aw_fire   = s_axi_awvalid && s_axi_awready;
  wire        w_fire    = s_axi_wvalid && s_axi_wready;
  wire        do_write  = aw_held && w_held && !s_axi_bvalid;
  wire        ar_fire   = s_axi_arvalid && s_axi_arready;
  wire [7:0]  ar_idx    = s_axi_araddr[9:2];
  wire        stat_read = ar_fire && (ar_idx == `MCAS_STAT_IDX);
  wire        sec_summary = |sec;
  wire [7:0]  status    = {sec_summary, alarm};
  wire [7:0]  events    = {sec_summary, viol};

  // Alarm and secondary inputs come from other logic domains
  always @(posedge aclk) begin
    if (!aresetn) begin
      viol_s1 <= 7'h00;
      viol    <= 7'h00;
      sec_s1  <= 8'h00;
      sec     <= 8'h00;
    end else begin
      viol_s1 <= limit_violation;
      viol    <= viol_s1;
      sec_s1  <= secondary_status;
      sec     <= sec_s1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ready_cnt <= 16'h0000;
      ready     <= 1'b0;
    end else if (!ready) begin
      if (ready_cnt >= READY_CYCLES[15:0] - 16'h0001)
        ready <= 1'b1;
      else
        ready_cnt <= ready_cnt + 16'h0001;
    end
  end

  // Write channel: address and data accepted in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_idx        <= 8'h00;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MCAS_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_held       <= 1'b1;
        aw_idx        <= s_axi_awaddr[9:2];
        s_axi_awready <= 1'b0;
      end
      if (w_fire) begin
        w_held       <= 1'b1;
        w_byte       <= s_axi_wdata[7:0];
        w_lane0      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `MCAS_RESP_OKAY : `MCAS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @* begin
    case (aw_idx)
      `MCAS_CFG_IDX, `MCAS_STAT_IDX, `MCAS_IRQ_EN_IDX, `MCAS_IRQ_CLR_IDX: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always @* begin
    next_cfg = cfg;
    if (do_write && w_lane0 && aw_idx == `MCAS_CFG_IDX) begin
      if (cfg[`MCAS_CFG_LOCK])
        next_cfg = (cfg & `MCAS_CFG_LOCKABLE) | (w_byte & ~`MCAS_CFG_LOCKABLE);
      else
        next_cfg = w_byte;
      next_cfg[`MCAS_CFG_FULL] = w_byte[`MCAS_CFG_FULL];
      next_cfg[`MCAS_CFG_LOCK] = cfg[`MCAS_CFG_LOCK] | w_byte[`MCAS_CFG_LOCK];
    end
    next_cfg[`MCAS_CFG_READY] = ready;
  end

  always @(posedge aclk) begin
    if (!aresetn)
      cfg <= `MCAS_CFG_RESET;
    else
      cfg <= next_cfg;
  end

  // controls driven to monitor, fan and bus logic
  always @(posedge aclk) begin
    if (!aresetn) begin
      monitor_run          <= 1'b0;
      config_locked        <= 1'b0;
      fans_full_speed      <= 1'b0;
      power_report         <= 1'b0;
      spinup_pulse_disable <= 1'b0;
      bus_timeout_disable  <= 1'b0;
      supply_scale_select  <= 1'b0;
    end else begin
      monitor_run          <= next_cfg[`MCAS_CFG_RUN];
      config_locked        <= next_cfg[`MCAS_CFG_LOCK];
      fans_full_speed      <= next_cfg[`MCAS_CFG_FULL];
      power_report         <= next_cfg[`MCAS_CFG_POWER];
      spinup_pulse_disable <= next_cfg[`MCAS_CFG_SPIN];
      bus_timeout_disable  <= next_cfg[`MCAS_CFG_BUS_TIMEOUT_DISABLE];
      supply_scale_select  <= next_cfg[`MCAS_CFG_SCALE];
    end
  end

  // latch wins over clearing read, writes ignored
  always @(posedge aclk) begin
    if (!aresetn)
      alarm <= 7'h00;
    else if (stat_read)
      alarm <= viol;
    else
      alarm <= alarm | viol;
  end

  // Interrupt status: set wins over write-one-to-clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= 8'h00;
      irq_en   <= 8'h00;
    end else begin
      if (do_write && w_lane0 && aw_idx == `MCAS_IRQ_EN_IDX)
        irq_en <= w_byte;
      if (do_write && w_lane0 && aw_idx == `MCAS_IRQ_CLR_IDX)
        irq_stat <= (irq_stat & ~w_byte) | events;
      else
        irq_stat <= irq_stat | events;
    end
  end

  always @* begin
    next_irq = |(irq_stat & irq_en);
  end

  always @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= next_irq;
  end

  // Read decode; clear register reads as zero
  always @* begin
    rd_ok  = 1'b1;
    rd_val = 8'h00;
    case (ar_idx)
      `MCAS_CFG_IDX:      rd_val = cfg;
      `MCAS_STAT_IDX:     rd_val = status;
      `MCAS_IRQ_EN_IDX:   rd_val = irq_en;
      `MCAS_IRQ_STAT_IDX: rd_val = irq_stat;
      `MCAS_IRQ_CLR_IDX:  rd_val = 8'h00;
      default:            rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `MCAS_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_val};
      s_axi_rresp   <= rd_ok ? `MCAS_RESP_OKAY : `MCAS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

/* tb/mcas_alarm_src.sv */
// Far-side alarm source driving violation and secondary status levels
`timescale 1ns/10ps
module mcas_alarm_src (
  input  wire       aclk,
  input  wire [6:0] set_viol,
  input  wire [7:0] set_sec,
  output reg  [6:0] limit_violation,
  output reg  [7:0] secondary_status
);
  initial begin
    limit_violation = 7'h00;
    secondary_status = 8'h00;
  end
  // levels held while a fault lasts
  always @(posedge aclk) begin
    limit_violation <= set_viol;
    secondary_status <= set_sec;
  end
endmodule

/* tb/mcas_checker.sv */
// Bus and lock checks on the register block ports
`timescale 1ns/10ps
module mcas_checker #(
  parameter READY_CYCLES = 250
) (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire        monitor_run,
  input wire        config_locked,
  input wire        power_report,
  input wire        bus_timeout_disable,
  input wire        supply_scale_select
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_lock_sticky: assert property (config_locked |=> config_locked)
    else $error("lock bit dropped");
  a_run_frozen: assert property (config_locked |=> $stable(monitor_run))
    else $error("run bit moved while locked");
  a_locked_fields: assert property (config_locked |=>
    $stable({power_report, bus_timeout_disable, supply_scale_select}))
    else $error("lockable field moved while locked");
  a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read response late");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
endmodule
bind mcas_regs mcas_checker #(.READY_CYCLES(READY_CYCLES)) u_chk (.*);

/* tb/mcas_regs_bench.sv */
// Self-checking bench for the configuration and alarm register block
`timescale 1ns/10ps
`include "mcas_map.vh"
module mcas_regs_bench;
  localparam RDY = 40;
  reg         aclk = 1'b0, aresetn = 1'b0;
  reg  [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg  [6:0]  set_viol = 7'h00, v, p;
  reg  [7:0]  set_sec = 8'h00;
  wire [6:0]  limit_violation;
  wire [7:0]  secondary_status;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        monitor_run, config_locked, fans_full_speed, power_report, irq;
  wire        spinup_pulse_disable, bus_timeout_disable, supply_scale_select;
  integer     bad_count = 0, total_checks = 0, seed = 32'h74C1, cyc = 0;
  reg  [33:0] q[$];
  mcas_regs #(.READY_CYCLES(RDY)) dut (.*);
  mcas_alarm_src far (.aclk(aclk), .set_viol(set_viol), .set_sec(set_sec),
    .limit_violation(limit_violation), .secondary_status(secondary_status));
  initial forever #2 aclk = ~aclk;
  task final_report;
    begin
      if (bad_count == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task cmp(input [33:0] g, input [33:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] i, input [7:0] d, input [1:0] r);
    begin
      @(posedge aclk);
      q.push_back({r, 32'h0});
      s_axi_awaddr <= {22'h0, i, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] i, input [7:0] e);
    begin
      @(posedge aclk);
      q.push_back({`MCAS_RESP_OKAY, 24'h0, e});
      s_axi_araddr <= {22'h0, i, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
    end
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      final_report;
    end
    if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, q.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmp({s_axi_bresp, 32'h0}, q.pop_front());
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`MCAS_CFG_IDX, 8'h00);
    rd(`MCAS_STAT_IDX, 8'h00);
    repeat (RDY) @(posedge aclk);
    rd(`MCAS_CFG_IDX, 8'h04);
    wr(`MCAS_CFG_IDX, 8'hF9, `MCAS_RESP_OKAY);
    cmp({27'h0, supply_scale_select, bus_timeout_disable, spinup_pulse_disable, power_report, fans_full_speed, config_locked, monitor_run}, 34'h7D);
    rd(`MCAS_CFG_IDX, 8'hFD);
    v = $random(seed) | 7'h01;
    p = v & $random(seed) | 7'h01;
    set_viol <= v;
    repeat (6) @(posedge aclk);
    set_viol <= p;
    repeat (6) @(posedge aclk);
    rd(`MCAS_STAT_IDX, {1'b0, v});
    rd(`MCAS_STAT_IDX, {1'b0, p});
    set_sec <= 8'h10;
    wr(`MCAS_STAT_IDX, 8'h00, `MCAS_RESP_OKAY);
    repeat (6) @(posedge aclk);
    rd(`MCAS_STAT_IDX, {1'b1, p});
    wr(`MCAS_IRQ_EN_IDX, 8'hFF, `MCAS_RESP_OKAY);
    repeat (3) @(posedge aclk);
    cmp({33'h0, irq}, 34'h1);
    wr(`MCAS_IRQ_EN_IDX, 8'h00, `MCAS_RESP_OKAY);
    repeat (3) @(posedge aclk);
    cmp({33'h0, irq}, 34'h0);
    set_viol <= 7'h00;
    set_sec <= 8'h00;
    repeat (6) @(posedge aclk);
    wr(`MCAS_IRQ_CLR_IDX, 8'hFF, `MCAS_RESP_OKAY);
    wr(`MCAS_IRQ_EN_IDX, 8'hFF, `MCAS_RESP_OKAY);
    repeat (3) @(posedge aclk);
    cmp({33'h0, irq}, 34'h0);
    rd(`MCAS_IRQ_STAT_IDX, 8'h00);
    wr(`MCAS_CFG_IDX, 8'h02, `MCAS_RESP_OKAY);
    wr(`MCAS_CFG_IDX, 8'hFF, `MCAS_RESP_OKAY);
    cmp({27'h0, supply_scale_select, bus_timeout_disable, spinup_pulse_disable, power_report, fans_full_speed, config_locked, monitor_run}, 34'h16);
    rd(`MCAS_CFG_IDX, 8'h2E);
    wr(`MCAS_CFG_IDX, 8'h00, `MCAS_RESP_OKAY);
    wr(8'h60, 8'hFF, `MCAS_RESP_SLVERR);
    rd(`MCAS_CFG_IDX, 8'h06);
    final_report;
  end
endmodule
